/* File: hdl/hdsc_ctrl.sv */
// command, seek, sector search and transfer logic of the disk controller
`timescale 1ns/1ps
// Overview of operation
// - seek interrupt only after drive reports head arrived and settled.
// - a clean header acts only on full match of cylinder, head and sector.
// - read delivers three header bytes then data; check bytes are never delivered.
// - matched sector requests dma per byte; completion interrupts, ends command.
// - record missing or flag means no data delivered; data check error means suspect data.
// - write generates marks and check bytes itself; format takes header sync from the host image.
// - write ending in any error leaves sector data unwritten.
// - access commands wait for drive ready, run, then interrupt.
// - reset and drive selection never raise the interrupt.
// - head byte bit 3 set aborts access with flagged sector status.
// - unflagged defective sector shows as check error only.
// - data field: zeros, address mark, data mark, data, check, zeros, gap.
// - separate read command omits header bytes; original read keeps them.
// - status read clears done and error flags only if done already set.
// - busy shows only controller activity for any command.
// - status byte: ready, fault, check, missing, flagged, done, busy.
// - drive/head byte: head in upper nibble, drive selects in bits 1 and 0.
module hdsc_ctrl import hdsc_pkg::*; (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic [7:0] io_addr_i,
	input wire logic io_wr_i,
	input wire logic io_rd_i,
	input wire logic [7:0] io_wdata_i,
	output logic [7:0] io_rdata_o,
	output logic dma_req_o,
	output logic irq_o,
	output logic [3:0] head_select_o,
	output logic drive_select_two_o,
	output logic drive_select_one_o,
	input wire logic drive_ready_i,
	input wire logic write_fault_i,
	input wire logic sector_512_i,
	input wire logic index_i,
	input wire logic track0_i,
	input wire logic seek_done_i,
	output logic step_o,
	output logic step_dir_in_o,
	input wire logic rd_valid_i,
	input wire logic rd_mark_i,
	input wire logic [7:0] rd_byte_i,
	output logic wr_gate_o,
	output logic wr_valid_o,
	output logic [7:0] wr_byte_o,
	input wire logic wr_take_i
);
	typedef enum logic [3:0] {S_IDLE, S_WAITRDY, S_STEP, S_SETTLE, S_HUNT, S_HDR, S_HCHK,
		S_HPUSH, S_DMARK, S_RDATA, S_DCHK, S_DRAIN, S_WRITE, S_DONE} hdsc_state_t;
	typedef enum logic [2:0] {SG_ZERO, SG_AM, SG_DM, SG_BODY, SG_CRC, SG_TAIL,
		SG_GAP} hdsc_seg_t;

	hdsc_state_t state, next_state;
	hdsc_seg_t seg, seg_next;
	logic [7:0] drive_head_select, cs_lo, cs_hi, tgt_lo, tgt_hi;
	logic cs_ptr, tgt_ptr;
	logic [7:0] op_code, hdr_cyl, hdr_head, hdr_sec;
	logic size512, recalibrate_cmd;
	logic [9:0] cnt, wcnt, dma_left;
	logic [10:0] steps_left;
	logic [7:0] step_tmr;
	logic [2:0] rev_cnt;
	logic task_done_flag, record_missing_flag, flagged_sector_status, crc_flag;
	logic w_end, crc_lag;
	logic [15:0] crc;
	logic [7:0] seg_byte;
	logic [9:0] seg_len;
	hdsc_fifo_if #(.W(FIFO_W)) fq ();

	// port decode
	wire wr_dh = io_wr_i && io_addr_i == PORT_DRV_HEAD;
	wire wr_csd = io_wr_i && io_addr_i == PORT_CSD;
	wire wr_tgt = io_wr_i && io_addr_i == PORT_TGT;
	wire wr_cmd = io_wr_i && io_addr_i == PORT_CMD;
	wire rd_stat = io_rd_i && io_addr_i == PORT_STATUS;
	wire rd_csd = io_rd_i && io_addr_i == PORT_CSD;
	wire idle = state == S_IDLE;

	wire cmd_known = io_wdata_i == CMD_READ || io_wdata_i == CMD_READ_DATA_ONLY ||
		io_wdata_i == CMD_WRITE || io_wdata_i == CMD_FORMAT ||
		io_wdata_i == CMD_SEEK || io_wdata_i == CMD_RECALIBRATE_CMD;
	wire cmd_go = wr_cmd && idle && cmd_known;
	wire cmd_move = io_wdata_i == CMD_SEEK || io_wdata_i == CMD_RECALIBRATE_CMD;
	wire op_fmt = op_code == CMD_FORMAT;
	wire op_wr = op_code == CMD_WRITE;
	wire op_out = op_wr || op_fmt;
	// header bytes only for the original read
	wire with_hdr = op_code == CMD_READ;
	wire op_rd = with_hdr || op_code == CMD_READ_DATA_ONLY;
	wire [9:0] sect_len = size512 ? SECT_LARGE : SECT_SMALL;
	wire [10:0] old_cyl = {cs_hi[2:0], cs_lo};
	wire [10:0] new_cyl = {tgt_hi[2:0], tgt_lo};

	wire hdr_match = hdr_cyl == tgt_lo && hdr_head[2:0] == tgt_hi[2:0] &&
		hdr_head[7:4] == drive_head_select[7:4] && hdr_sec == cs_lo;
	wire hdr_bad = hdr_head[HDR_BAD_BIT];
	wire crc_ok = crc == '0;
	wire hunting = state == S_HUNT || state == S_HDR || state == S_DMARK;
	wire hunt_to = hunting && index_i && rev_cnt == RNF_REVS - 3'h1;
	wire mark_in = rd_valid_i && rd_mark_i;
	wire step_end = recalibrate_cmd ? track0_i : steps_left == '0;
	wire step_fire = state == S_STEP && !step_end && step_tmr == '0;
	wire rd_push = (state == S_HPUSH) || (state == S_RDATA && rd_valid_i && cnt < sect_len);
	// dma only in write state, after match or after ready for format; earlier bytes would clobber the sector byte
	wire host_push = wr_csd && op_out && dma_left != '0 && state == S_WRITE;
	wire rd_pop = rd_csd && op_rd && fq.out_valid;
	wire byte_avail = seg == SG_BODY ? fq.out_valid : !(seg == SG_CRC && wcnt == '0 && crc_lag);
	wire wl = state == S_WRITE && !w_end && (!wr_valid_o || wr_take_i) && byte_avail;
	wire w_clr = wl && (seg == SG_DM || (op_fmt && seg == SG_BODY && wcnt == '0));
	wire w_en = wl && (seg == SG_DM || seg == SG_BODY);
	wire r_clr = mark_in && (state == S_DMARK || (state == S_HUNT && rd_byte_i == BYTE_HDR_SYNC));
	wire r_en = rd_valid_i && (r_clr || state == S_HDR || state == S_RDATA);

	// record missing set before any data is pushed
	wire set_rnf = hunt_to || (state == S_DMARK && mark_in && rd_byte_i != BYTE_DATA_MARK);
	// defects surface as check errors; fifo overrun also marks data suspect
	wire set_crc = ((state == S_HCHK || state == S_DCHK) && !crc_ok) ||
		(rd_push && !fq.in_ready);
	wire set_bad = state == S_HCHK && crc_ok && hdr_match && hdr_bad;
	wire set_tc = state == S_DONE;
	// clear only when done was set at the read
	wire clr_st = rd_stat && task_done_flag;
	// status layout; busy from controller state only
	wire [7:0] status_byte = {drive_ready_i, write_fault_i, 1'b0, crc_flag, record_missing_flag,
		flagged_sector_status, task_done_flag, !idle};

	assign fq.in_valid = rd_push || host_push;
	assign fq.in_data = state == S_HPUSH ? (cnt == 10'h000 ? hdr_cyl :
		cnt == 10'h001 ? hdr_head : hdr_sec) : (op_out ? io_wdata_i : rd_byte_i);
	assign fq.out_ready = rd_pop || (wl && seg == SG_BODY);
	assign head_select_o = drive_head_select[7:4];
	assign drive_select_two_o = drive_head_select[1];
	assign drive_select_one_o = drive_head_select[0];
	// interrupt follows the done flag only
	assign irq_o = task_done_flag;

	hdsc_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) i_hdsc_fifo (
		.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i),
		.flush_i(cmd_go),
		.f(fq)
	);

	hdsc_crc16 i_hdsc_crc16 (
		.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i),
		.clear_i(op_out ? w_clr : r_clr),
		.en_i(op_out ? w_en : r_en),
		.byte_i(op_out ? seg_byte : rd_byte_i),
		.crc_o(crc)
	);

	always_comb begin
		next_state = state;
		case (state)
			S_IDLE: if (cmd_go) begin
				// moves start without waiting for ready
				next_state = cmd_move ? S_STEP : S_WAITRDY;
			end
			S_WAITRDY: if (drive_ready_i) begin
				next_state = op_fmt ? S_WRITE : S_HUNT;
			end
			S_STEP: if (step_end) begin
				next_state = S_SETTLE;
			end
			S_SETTLE: if (seek_done_i) begin
				next_state = S_DONE;
			end
			S_HUNT: if (hunt_to) begin
				next_state = S_DONE;
			end else if (r_clr) begin
				next_state = S_HDR;
			end
			S_HDR: if (hunt_to) begin
				next_state = S_DONE;
			end else if (rd_valid_i && cnt == N_HDR_BYTES + N_CRC - 10'h001) begin
				next_state = S_HCHK;
			end
			S_HCHK: if (!crc_ok || (hdr_match && hdr_bad)) begin
				next_state = S_DONE;
			end else if (!hdr_match) begin
				next_state = S_HUNT;
			end else if (op_out) begin
				next_state = S_WRITE;
			end else begin
				next_state = with_hdr ? S_HPUSH : S_DMARK;
			end
			S_HPUSH: if (cnt == N_HDR_BYTES - 10'h001) begin
				next_state = S_DMARK;
			end
			S_DMARK: if (hunt_to || set_rnf) begin
				next_state = S_DONE;
			end else if (mark_in) begin
				next_state = S_RDATA;
			end
			S_RDATA: if (rd_valid_i && cnt == sect_len + N_CRC - 10'h001) begin
				next_state = S_DCHK;
			end
			S_DCHK: next_state = S_DRAIN;
			// complete once dma has drained every byte
			S_DRAIN: if (!fq.out_valid) begin
				next_state = S_DONE;
			end
			S_WRITE: if (w_end && !wr_valid_o) begin
				next_state = S_DONE;
			end
			S_DONE: next_state = S_IDLE;
			default: next_state = S_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			state <= S_IDLE;
			cnt <= '0;
		end else begin
			state <= next_state;
			cnt <= (next_state != state) ? '0 : cnt + 10'(((state == S_HDR ||
				state == S_RDATA) && rd_valid_i) || state == S_HPUSH);
		end
	end

	// host ports; byte pointers advance only between commands
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			drive_head_select <= RESET_BYTE;
			{cs_lo, cs_hi, tgt_lo, tgt_hi} <= '0;
			cs_ptr <= 1'b0;
			tgt_ptr <= 1'b0;
		end else begin
			if (wr_dh) drive_head_select <= io_wdata_i;
			// data bytes land in the sector byte too
			if (wr_csd && !cs_ptr) cs_lo <= io_wdata_i;
			if (wr_csd && cs_ptr) cs_hi <= io_wdata_i;
			if (wr_tgt && !tgt_ptr) tgt_lo <= io_wdata_i;
			if (wr_tgt && tgt_ptr) tgt_hi <= io_wdata_i;
			cs_ptr <= wr_cmd ? 1'b0 : cs_ptr ^ (wr_csd && idle);
			tgt_ptr <= wr_cmd ? 1'b0 : tgt_ptr ^ (wr_tgt && idle);
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			op_code <= '0;
			size512 <= 1'b0;
			recalibrate_cmd <= 1'b0;
			dma_left <= '0;
		end else if (cmd_go) begin
			op_code <= io_wdata_i;
			size512 <= sector_512_i;
			recalibrate_cmd <= io_wdata_i == CMD_RECALIBRATE_CMD;
			dma_left <= io_wdata_i == CMD_FORMAT ? N_HDR_IMAGE :
				io_wdata_i == CMD_WRITE ? (sector_512_i ? SECT_LARGE : SECT_SMALL) : '0;
		end else if (host_push && fq.in_ready) begin
			dma_left <= dma_left - 10'h001;
		end
	end

	// seek stepping and revolution count
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			steps_left <= '0;
			step_dir_in_o <= 1'b0;
			step_tmr <= '0;
			step_o <= 1'b0;
			rev_cnt <= '0;
		end else begin
			if (cmd_go) begin
				steps_left <= new_cyl > old_cyl ? new_cyl - old_cyl : old_cyl - new_cyl;
				step_dir_in_o <= io_wdata_i == CMD_SEEK && new_cyl > old_cyl;
			end else if (step_fire) begin
				steps_left <= steps_left - 11'h001;
			end
			step_tmr <= (state != S_STEP || step_tmr == STEP_GAP - 8'h01) ? '0 : step_tmr + 8'h01;
			step_o <= step_fire;
			rev_cnt <= state == S_WAITRDY ? '0 : rev_cnt + 3'(hunting && index_i);
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			{hdr_cyl, hdr_head, hdr_sec} <= '0;
		end else if (state == S_HDR && rd_valid_i) begin
			if (cnt == 10'h000) hdr_cyl <= rd_byte_i;
			if (cnt == 10'h001) hdr_head <= rd_byte_i;
			if (cnt == 10'h002) hdr_sec <= rd_byte_i;
		end
	end

	// status flags; a set in the clearing cycle wins
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			task_done_flag <= 1'b0;
			record_missing_flag <= 1'b0;
			flagged_sector_status <= 1'b0;
			crc_flag <= 1'b0;
		end else begin
			// done flag raised at end of every command
			task_done_flag <= (task_done_flag && !clr_st) || set_tc;
			record_missing_flag <= (record_missing_flag && !clr_st) || set_rnf;
			// flagged sector aborts with its own status
			flagged_sector_status <= (flagged_sector_status && !clr_st) || set_bad;
			crc_flag <= (crc_flag && !clr_st) || set_crc;
		end
	end

	// dma paced by fifo level; drops the cycle after each transfer
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			dma_req_o <= 1'b0;
			io_rdata_o <= RESET_BYTE;
		end else begin
			dma_req_o <= op_rd ? (fq.out_valid && !rd_pop && !idle) :
				(op_out && state == S_WRITE && dma_left != '0 && fq.in_ready && !host_push);
			io_rdata_o <= rd_stat ? status_byte : (rd_pop ? fq.out_data : RESET_BYTE);
		end
	end

	// field layout; marks and check bytes made here
	always_comb begin
		case (seg)
			SG_ZERO: seg_len = op_fmt ? N_FMT_ZEROS : N_DATA_ZEROS;
			SG_BODY: seg_len = op_fmt ? N_HDR_IMAGE : sect_len;
			SG_CRC: seg_len = N_CRC;
			SG_TAIL: seg_len = op_fmt ? N_FMT_TAIL : N_TAIL_ZEROS;
			SG_GAP: seg_len = op_fmt ? sect_len : N_GAP;
			default: seg_len = 10'h001;
		endcase
		case (seg)
			SG_AM: seg_byte = BYTE_AM;
			SG_DM: seg_byte = BYTE_DATA_MARK;
			// format body is the host image, sync byte included
			SG_BODY: seg_byte = fq.out_data;
			SG_CRC: seg_byte = wcnt == '0 ? crc[15:8] : crc[7:0];
			SG_GAP: seg_byte = BYTE_FILL;
			default: seg_byte = BYTE_ZERO;
		endcase
		case (seg)
			SG_ZERO: seg_next = SG_AM;
			SG_AM: seg_next = op_fmt ? SG_BODY : SG_DM;
			SG_DM: seg_next = SG_BODY;
			SG_BODY: seg_next = SG_CRC;
			SG_CRC: seg_next = SG_TAIL;
			default: seg_next = SG_GAP;
		endcase
	end

	// writer runs after a clean matching header, or straight after drive ready for format
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i || state != S_WRITE) begin
			seg <= SG_ZERO;
			wcnt <= '0;
			w_end <= 1'b0;
			wr_valid_o <= 1'b0;
			wr_byte_o <= RESET_BYTE;
		end else if (wl) begin
			wr_byte_o <= seg_byte;
			wr_valid_o <= 1'b1;
			wcnt <= wcnt == seg_len - 10'h001 ? '0 : wcnt + 10'h001;
			if (wcnt == seg_len - 10'h001 && seg == SG_GAP) w_end <= 1'b1;
			if (wcnt == seg_len - 10'h001 && seg != SG_GAP) seg <= seg_next;
		end else if (wr_take_i) begin
			wr_valid_o <= 1'b0;
		end
	end

	// check value needs a cycle to settle before its first byte
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			crc_lag <= 1'b0;
			wr_gate_o <= 1'b0;
		end else begin
			crc_lag <= w_en;
			wr_gate_o <= next_state == S_WRITE;
		end
	end
endmodule

/* File: hdl/hdsc_pkg.sv */
// constants shared by the hard disk sector controller
package hdsc_pkg;
	localparam logic [7:0] PORT_DRV_HEAD = 8'h20;
	localparam logic [7:0] PORT_CSD = 8'h21;
	localparam logic [7:0] PORT_TGT = 8'h22;
	localparam logic [7:0] PORT_STATUS = 8'h23;
	localparam logic [7:0] PORT_CMD = 8'h24;
	localparam logic [7:0] CMD_READ = 8'h01;
	localparam logic [7:0] CMD_WRITE = 8'h02;
	localparam logic [7:0] CMD_FORMAT = 8'h03;
	localparam logic [7:0] CMD_SEEK = 8'h04;
	localparam logic [7:0] CMD_RECALIBRATE_CMD = 8'h05;
	localparam logic [7:0] CMD_READ_DATA_ONLY = 8'h09;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] BYTE_AM = 8'ha1;
	localparam logic [7:0] BYTE_DATA_MARK = 8'hf8;
	localparam logic [7:0] BYTE_HDR_SYNC = 8'hfe;
	localparam logic [7:0] BYTE_FILL = 8'h4e;
	localparam logic [9:0] N_DATA_ZEROS = 10'h00c;
	localparam logic [9:0] N_TAIL_ZEROS = 10'h003;
	localparam logic [9:0] N_GAP = 10'h01d;
	localparam logic [9:0] N_FMT_ZEROS = 10'h00e;
	localparam logic [9:0] N_FMT_TAIL = 10'h00a;
	localparam logic [9:0] N_HDR_IMAGE = 10'h004;
	localparam logic [9:0] N_HDR_BYTES = 10'h003;
	localparam logic [9:0] N_CRC = 10'h002;
	localparam logic [9:0] SECT_SMALL = 10'h100;
	localparam logic [9:0] SECT_LARGE = 10'h200;
	localparam int unsigned HDR_BAD_BIT = 3;
	localparam logic [2:0] RNF_REVS = 3'h4;
	localparam logic [7:0] STEP_GAP = 8'h10;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam int unsigned FIFO_W = 8;
	localparam int unsigned FIFO_DEPTH = 4;
endpackage

/* File: hdl/hdsc_fifo_if.sv */
// byte stream between controller and its fifo
`timescale 1ns/1ps
interface hdsc_fifo_if #(parameter int unsigned W = 8);
	logic in_valid;
	logic in_ready;
	logic [W-1:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [W-1:0] out_data;
	modport ctl(output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
	modport store(input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
endinterface

/* File: hdl/hdsc_fifo.sv */
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module hdsc_fifo #(
	parameter int unsigned W = 8,
	parameter int unsigned DEPTH = 4
) (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic flush_i,
	hdsc_fifo_if.store f
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wp;
	logic [AW-1:0] rp;
	logic [AW:0] cnt;
	wire push = f.in_valid && f.in_ready;
	wire pop = f.out_valid && f.out_ready;
	assign f.in_ready = cnt != (AW+1)'(DEPTH);
	assign f.out_valid = cnt != '0;
	assign f.out_data = mem[rp];

	always_ff @(posedge clk_sys_i) begin
		if (push) begin
			mem[wp] <= f.in_data;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i || flush_i) begin
			wp <= '0;
			rp <= '0;
			cnt <= '0;
		end else begin
			wp <= push ? ((wp == AW'(DEPTH-1)) ? '0 : wp + 1'b1) : wp;
			rp <= pop ? ((rp == AW'(DEPTH-1)) ? '0 : rp + 1'b1) : rp;
			cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

/* File: hdl/hdsc_crc16.sv */
// byte-wide check code accumulator, msb first
`timescale 1ns/1ps
module hdsc_crc16 import hdsc_pkg::*; (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic clear_i,
	input wire logic en_i,
	input wire logic [7:0] byte_i,
	output logic [15:0] crc_o
);
	logic [15:0] next_crc;
	always_comb begin
		next_crc = clear_i ? CRC_INIT : crc_o;
		for (int i = 7; i >= 0; i--) begin
			next_crc = (next_crc[15] ^ byte_i[i]) ? {next_crc[14:0], 1'b0} ^ CRC_POLY
				: {next_crc[14:0], 1'b0};
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			crc_o <= CRC_INIT;
		end else if (en_i) begin
			crc_o <= next_crc;
		end else if (clear_i) begin
			crc_o <= CRC_INIT;
		end
	end
endmodule

/* File: dv/hdsc_ctrl_properties.sv */
// port assertions for the disk controller
`timescale 1ns/1ps
module hdsc_ctrl_checker import hdsc_pkg::*; (
	input logic clk_sys_i,
	input logic resetn_i,
	input logic [7:0] io_addr_i,
	input logic io_wr_i,
	input logic io_rd_i,
	input logic [7:0] io_wdata_i,
	input logic [7:0] io_rdata_o,
	input logic dma_req_o,
	input logic irq_o,
	input logic [3:0] head_select_o,
	input logic drive_select_two_o,
	input logic drive_select_one_o,
	input logic drive_ready_i,
	input logic step_o,
	input logic wr_gate_o,
	input logic wr_valid_o,
	input logic [7:0] wr_byte_o,
	input logic wr_take_i
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);
	wire st_rd = io_rd_i && io_addr_i == PORT_STATUS;
	wire dh_wr = io_wr_i && io_addr_i == PORT_DRV_HEAD;
	wire [5:0] dh_w = {io_wdata_i[7:4], io_wdata_i[1:0]};
	a_rdata_quiet: assert property (!io_rd_i |=> io_rdata_o == 8'h00)
		else $error("read data not zero when idle");
	a_status_fixed: assert property (st_rd |=> !io_rdata_o[5] && io_rdata_o[7] == $past(drive_ready_i))
		else $error("status ready or spare bit wrong");
	a_status_clear: assert property (st_rd && irq_o |=> !irq_o && io_rdata_o[1])
		else $error("status read did not clear done");
	a_irq_hold: assert property (irq_o && !st_rd |=> irq_o)
		else $error("interrupt dropped without status read");
	a_select_quiet: assert property (dh_wr && !irq_o |=> !irq_o)
		else $error("drive select raised interrupt");
	a_head_field: assert property (dh_wr |=> {head_select_o, drive_select_two_o, drive_select_one_o} == $past(dh_w))
		else $error("drive head fields wrong");
	a_step_space: assert property (step_o |=> !step_o [*8])
		else $error("step pulses too close");
	a_wr_hold: assert property (wr_valid_o && !wr_take_i |=> wr_valid_o && $stable(wr_byte_o))
		else $error("write byte changed before take");
	a_gate_cover: assert property (wr_valid_o |-> wr_gate_o)
		else $error("write byte outside gate");
	a_done_quiet: assert property ($rose(irq_o) |-> !wr_gate_o && !dma_req_o)
		else $error("done while transfer active");
	c_irq: cover property ($rose(irq_o));
	c_step: cover property (step_o);
	c_take: cover property (wr_valid_o && wr_take_i);
	c_dma: cover property (dma_req_o && io_rd_i);
endmodule
bind hdsc_ctrl hdsc_ctrl_checker i_hdsc_ctrl_checker (.clk_sys_i, .resetn_i, .io_addr_i, .io_wr_i,
	.io_rd_i, .io_wdata_i, .io_rdata_o, .dma_req_o, .irq_o, .head_select_o, .drive_select_two_o,
	.drive_select_one_o, .drive_ready_i, .step_o, .wr_gate_o, .wr_valid_o, .wr_byte_o, .wr_take_i);

/* File: dv/hdsc_drive_model.sv */
// behavioural drive: track playback, stepping, write capture
`timescale 1ns/1ps
module hdsc_drive_model import hdsc_pkg::*; #(
	parameter int SETTLE = 64,
	parameter int BYTE_GAP = 8
) (
	input logic clk_sys_i,
	input logic [7:0] hdr_hb_i,
	input logic [7:0] hdr_sect_i,
	input logic crc_bad_i,
	input logic step_i,
	input logic step_dir_in_i,
	input logic wr_gate_i,
	input logic wr_valid_i,
	input logic [7:0] wr_byte_i,
	output logic wr_take_o,
	output logic index_o,
	output logic track0_o,
	output logic seek_done_o,
	output logic rd_valid_o,
	output logic rd_mark_o,
	output logic [7:0] rd_byte_o
);
	logic [10:0] cyl = 11'h000;
	int settle = 0;
	int wcnt = 0;
	logic [15:0] crc;
	logic [7:0] wcap [0:15];
	assign track0_o = cyl == 11'h000;
	assign seek_done_o = settle == 0 && !step_i;
	always @(posedge clk_sys_i) begin
		if (step_i) begin
			settle <= SETTLE;
			cyl <= step_dir_in_i ? cyl + 11'h001 : cyl - 11'h001;
		end else if (settle != 0) begin
			settle <= settle - 1;
		end
	end
	initial wr_take_o = 1'b0;
	// take every other cycle, so a stuck byte shows up
	always @(posedge clk_sys_i) begin
		wr_take_o <= wr_valid_i && !wr_take_o;
		if (wr_valid_i && wr_take_o) begin
			if (wcnt < 16) wcap[wcnt] <= wr_byte_i;
			wcnt <= wcnt + 1;
		end
	end
	task automatic put(input logic [7:0] b, input logic m);
		repeat (BYTE_GAP - 1) @(posedge clk_sys_i);
		rd_byte_o <= b;
		rd_mark_o <= m;
		rd_valid_o <= 1'b1;
		for (int i = 7; i >= 0; i--) crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ b[i]) ? CRC_POLY : 16'h0000);
		@(posedge clk_sys_i);
		rd_valid_o <= 1'b0;
		rd_mark_o <= 1'b0;
		// stale bus shows inverted data, never the old byte
		rd_byte_o <= ~b;
	endtask
	// a set flip spoils the check bytes so the data turns suspect
	task automatic putcrc(input logic flip);
		logic [15:0] c;
		c = crc ^ {15'h0000, flip};
		put(c[15:8], 1'b0);
		put(c[7:0], 1'b0);
	endtask
	initial begin
		index_o = 1'b0;
		rd_valid_o = 1'b0;
		rd_mark_o = 1'b0;
		rd_byte_o = 8'h00;
		forever begin
			@(posedge clk_sys_i);
			index_o <= 1'b1;
			@(posedge clk_sys_i);
			index_o <= 1'b0;
			crc = CRC_INIT;
			put(BYTE_HDR_SYNC, 1'b1);
			put(cyl[7:0], 1'b0);
			put(hdr_hb_i | {5'h00, cyl[10:8]}, 1'b0);
			put(hdr_sect_i, 1'b0);
			putcrc(1'b0);
			repeat (16) @(posedge clk_sys_i);
			if (wr_gate_i) begin
				wait (!wr_gate_i);
			end else begin
				crc = CRC_INIT;
				put(BYTE_DATA_MARK, 1'b1);
				for (int k = 0; k < 256; k++) put(k[7:0] ^ 8'h5a, 1'b0);
				putcrc(crc_bad_i);
			end
		end
	end
endmodule

/* File: dv/tb_hdsc_ctrl.sv */
// self-checking bench for the disk controller
`timescale 1ns/1ps
module tb_hdsc_ctrl import hdsc_pkg::*;;
	logic clk_sys_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [7:0] io_addr_i = 8'h00;
	logic io_wr_i = 1'b0;
	logic io_rd_i = 1'b0;
	logic [7:0] io_wdata_i = 8'h00;
	logic drive_ready_i = 1'b1;
	logic write_fault_i = 1'b0;
	logic sector_512_i = 1'b0;
	logic [7:0] hdr_hb = 8'h10;
	logic [7:0] hdr_sect = 8'h05;
	logic crc_bad = 1'b0;
	logic [7:0] io_rdata_o, rd_byte_i, wr_byte_o;
	logic [3:0] head_select_o;
	logic dma_req_o, irq_o, drive_select_two_o, drive_select_one_o, index_i, track0_i;
	logic seek_done_i, step_o, step_dir_in_o, rd_valid_i, rd_mark_i, wr_gate_o, wr_valid_o, wr_take_i;
	int failures = 0;
	int samples_checked = 0;
	int cyc = 0;
	int steps = 0;
	int last_step = 0;
	int nq;
	logic [7:0] q [0:599];
	hdsc_ctrl i_hdsc_ctrl (.*);
	hdsc_drive_model i_hdsc_drive_model (.clk_sys_i(clk_sys_i), .hdr_hb_i(hdr_hb),
		.hdr_sect_i(hdr_sect), .crc_bad_i(crc_bad), .step_i(step_o), .step_dir_in_i(step_dir_in_o),
		.wr_gate_i(wr_gate_o), .wr_valid_i(wr_valid_o), .wr_byte_i(wr_byte_o),
		.wr_take_o(wr_take_i), .index_o(index_i), .track0_o(track0_i),
		.seek_done_o(seek_done_i), .rd_valid_o(rd_valid_i), .rd_mark_o(rd_mark_i),
		.rd_byte_o(rd_byte_i));
	always #2.5 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) begin
		cyc++;
		if (step_o === 1'b1) begin
			steps++;
			last_step = cyc;
		end
	end
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic close_out();
		if (failures == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys_i);
		io_addr_i = a;
		io_wdata_i = d;
		io_wr_i = 1'b1;
		@(negedge clk_sys_i);
		io_wr_i = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_sys_i);
		io_addr_i = a;
		io_rd_i = 1'b1;
		@(negedge clk_sys_i);
		io_rd_i = 1'b0;
		d = io_rdata_o;
	endtask
	task automatic st(input logic [7:0] exp);
		logic [7:0] d;
		rd(PORT_STATUS, d);
		chk("status", {8'h00, exp}, {8'h00, d});
	endtask
	// serves dma until the done interrupt, bounded
	task automatic run(input logic wmode);
		logic [7:0] d;
		nq = 0;
		for (int n = 0; n < 40000 && irq_o !== 1'b1; n++) begin
			@(negedge clk_sys_i);
			if (dma_req_o === 1'b1) begin
				if (wmode) begin
					wr(PORT_CSD, q[nq]);
				end else begin
					rd(PORT_CSD, d);
					q[nq] = d;
				end
				nq++;
			end
		end
		if (irq_o !== 1'b1) begin
			failures++;
			close_out();
		end
	endtask
	initial begin
		repeat (6) @(negedge clk_sys_i);
		resetn_i = 1'b1;
		st(8'h80);
		wr(PORT_CMD, 8'h07);
		st(8'h80);
		wr(PORT_CSD, 8'h00);
		wr(PORT_CSD, 8'h00);
		wr(PORT_TGT, 8'h02);
		wr(PORT_TGT, 8'h00);
		wr(PORT_CMD, CMD_SEEK);
		st(8'h81);
		run(1'b0);
		chk("steps", 16'h0002, steps[15:0]);
		chk("settle", 16'h0001, {15'h0000, cyc - last_step > 64});
		st(8'h82);
		st(8'h80);
		wr(PORT_DRV_HEAD, 8'h11);
		wr(PORT_CSD, 8'h05);
		repeat (4000) @(negedge clk_sys_i);
		drive_ready_i = 1'b0;
		wr(PORT_CMD, CMD_READ);
		write_fault_i = 1'b1;
		repeat (50) @(negedge clk_sys_i);
		st(8'h41);
		write_fault_i = 1'b0;
		drive_ready_i = 1'b1;
		run(1'b0);
		chk("read count", 16'h0103, nq[15:0]);
		chk("hdr cyl", 16'h0002, {8'h00, q[0]});
		chk("hdr head", 16'h0010, {8'h00, q[1]});
		chk("hdr sect", 16'h0005, {8'h00, q[2]});
		chk("data first", 16'h005a, {8'h00, q[3]});
		chk("data last", 16'h00a5, {8'h00, q[258]});
		st(8'h82);
		wr(PORT_CSD, 8'h05);
		wr(PORT_CMD, CMD_READ_DATA_ONLY);
		run(1'b0);
		chk("bare count", 16'h0100, nq[15:0]);
		chk("bare first", 16'h005a, {8'h00, q[0]});
		st(8'h82);
		wr(PORT_CSD, 8'h05);
		wr(PORT_CMD, CMD_WRITE);
		run(1'b1);
		chk("write dma", 16'h0100, nq[15:0]);
		chk("field len", 16'h0130, i_hdsc_drive_model.wcnt[15:0]);
		chk("lead zero", 16'h0000, {8'h00, i_hdsc_drive_model.wcap[11]});
		chk("addr mark", 16'h00a1, {8'h00, i_hdsc_drive_model.wcap[12]});
		chk("data mark", 16'h00f8, {8'h00, i_hdsc_drive_model.wcap[13]});
		chk("wr data", 16'h005a, {8'h00, i_hdsc_drive_model.wcap[14]});
		st(8'h82);
		crc_bad = 1'b1;
		wr(PORT_CSD, 8'h05);
		wr(PORT_CMD, CMD_READ);
		run(1'b0);
		crc_bad = 1'b0;
		chk("suspect dma", 16'h0103, nq[15:0]);
		st(8'h92);
		hdr_sect = 8'h06;
		wr(PORT_CSD, 8'h05);
		wr(PORT_CMD, CMD_READ);
		run(1'b0);
		chk("missing dma", 16'h0000, nq[15:0]);
		st(8'h8a);
		hdr_sect = 8'h05;
		hdr_hb = 8'h18;
		wr(PORT_CSD, 8'h05);
		wr(PORT_CMD, CMD_READ);
		run(1'b0);
		chk("flag dma", 16'h0000, nq[15:0]);
		st(8'h86);
		hdr_hb = 8'h10;
		q[0] = BYTE_HDR_SYNC;
		q[1] = 8'h02;
		q[2] = 8'h10;
		q[3] = 8'h05;
		wr(PORT_CMD, CMD_FORMAT);
		run(1'b1);
		chk("fmt dma", 16'h0004, nq[15:0]);
		chk("fmt len", 16'h024f, i_hdsc_drive_model.wcnt[15:0]);
		st(8'h82);
		wr(PORT_DRV_HEAD, 8'h12);
		wr(PORT_TGT, 8'h00);
		wr(PORT_TGT, 8'h00);
		chk("head sel", 16'h0001, {12'h000, head_select_o});
		chk("drive sel", 16'h0002, {14'h0000, drive_select_two_o, drive_select_one_o});
		wr(PORT_CMD, CMD_RECALIBRATE_CMD);
		run(1'b0);
		chk("recalibrate_cmd steps", 16'h0004, steps[15:0]);
		chk("recalibrate_cmd dir", 16'h0000, {15'h0000, step_dir_in_o});
		st(8'h82);
		close_out();
	end
endmodule
